// >>> design/ddpc_top.sv
// Dual data pointer control block: control register, select, adjust
`timescale 1ns/1ps
`default_nettype none
module ddpc_top (
    input  wire logic                        MCLK_IN,
    input  wire logic                        RSTN_IN,
    input  wire logic                        PSEL_IN,
    input  wire logic                        PENABLE_IN,
    input  wire logic                        PWRITE_IN,
    input  wire logic [ddpc_pkg::ADDR_W-1:0] PADDR_IN,
    input  wire logic [ddpc_pkg::DATA_W-1:0] PWDATA_IN,
    output logic      [ddpc_pkg::DATA_W-1:0] PRDATA_OUT,
    output logic                             PREADY_OUT,
    output logic                             PSLVERR_OUT,
    input  wire logic                        MOVE_DONE_IN,
    input  wire ddpc_pkg::ddpc_move_type     MOVE_KIND_IN,
    output logic      [ddpc_pkg::PTR_W-1:0]  ACTIVE_POINTER_OUT,
    output logic                             POINTER_SELECT_OUT
);
    import ddpc_pkg::*;

    logic              auto_swap_enable_q;
    ddpc_mode_type     shadow_mode_q;
    ddpc_mode_type     main_mode_q;
    logic              pointer_select_q;
    logic [PTR_W-1:0]  active_pointer;
    logic [PTR_W-1:0]  active_pointer_q;
    logic [BYTE_W-1:0] ctrl_view;
    logic              ptr_move;
    logic              wr_ctrl;
    logic              wr_lo;
    logic              wr_hi;

    ddpc_reg_if rif ();
    ddpc_ptr_if main_if ();
    ddpc_ptr_if shadow_if ();

    ddpc_apb_slave u_apb (
        .clk_in      (MCLK_IN),
        .rstn_in     (RSTN_IN),
        .psel_in     (PSEL_IN),
        .penable_in  (PENABLE_IN),
        .pwrite_in   (PWRITE_IN),
        .paddr_in    (PADDR_IN),
        .pwdata_in   (PWDATA_IN),
        .prdata_out  (PRDATA_OUT),
        .pready_out  (PREADY_OUT),
        .pslverr_out (PSLVERR_OUT),
        .r           (rif)
    );

    ddpc_ptr_unit u_main (
        .clk_in  (MCLK_IN),
        .rstn_in (RSTN_IN),
        .p       (main_if)
    );

    ddpc_ptr_unit u_shadow (
        .clk_in  (MCLK_IN),
        .rstn_in (RSTN_IN),
        .p       (shadow_if)
    );

    // PC-relative and index-register moves never qualify
    assign ptr_move = MOVE_DONE_IN
                      && (MOVE_KIND_IN == MV_EXT_PTR
                          || MOVE_KIND_IN == MV_CODE_PTR);

    assign wr_ctrl = rif.wr && (rif.idx == CTRL_IDX);
    assign wr_lo   = rif.wr && (rif.idx == PTR_LO_IDX);
    assign wr_hi   = rif.wr && (rif.idx == PTR_HI_IDX);

    // Mode and swap fields; spare bits 7 and 1 are never stored
    always_ff @(posedge MCLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            auto_swap_enable_q <= CTRL_RESET[SWAP_BIT];
            shadow_mode_q      <= ddpc_mode_type'(
                CTRL_RESET[SHADOW_MODE_LSB +: MODE_W]);
            main_mode_q        <= ddpc_mode_type'(
                CTRL_RESET[MAIN_MODE_LSB +: MODE_W]);
        end
        else if (wr_ctrl)
        begin
            auto_swap_enable_q <= rif.wdata[SWAP_BIT];
            shadow_mode_q      <= ddpc_mode_type'(
                rif.wdata[SHADOW_MODE_LSB +: MODE_W]);
            main_mode_q        <= ddpc_mode_type'(
                rif.wdata[MAIN_MODE_LSB +: MODE_W]);
        end
    end

    // Software write of the select beats a same-cycle auto-swap
    always_ff @(posedge MCLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            pointer_select_q <= CTRL_RESET[SEL_BIT];
        else if (wr_ctrl)
            pointer_select_q <= rif.wdata[SEL_BIT];
        else if (ptr_move && auto_swap_enable_q)
            pointer_select_q <= ~pointer_select_q;
    end

    // Readback image of the control register
    always_comb
    begin
        ctrl_view                                = CTRL_RESET;
        ctrl_view[SWAP_BIT]                      = auto_swap_enable_q;
        ctrl_view[SHADOW_MODE_LSB +: MODE_W]     = shadow_mode_q;
        ctrl_view[MAIN_MODE_LSB +: MODE_W]       = main_mode_q;
        ctrl_view[SEL_BIT]                       = pointer_select_q;
    end

    // Byte loads and adjust go only to the pointer now selected
    assign main_if.ld_lo   = wr_lo && !pointer_select_q;
    assign main_if.ld_hi   = wr_hi && !pointer_select_q;
    assign main_if.wbyte   = rif.wdata;
    assign main_if.step    = ptr_move && !pointer_select_q;
    assign main_if.mode    = main_mode_q;

    assign shadow_if.ld_lo = wr_lo && pointer_select_q;
    assign shadow_if.ld_hi = wr_hi && pointer_select_q;
    assign shadow_if.wbyte = rif.wdata;
    assign shadow_if.step  = ptr_move && pointer_select_q;
    assign shadow_if.mode  = shadow_mode_q;

    assign active_pointer  = pointer_select_q ? shadow_if.value
                                              : main_if.value;

    // Register map decode for the bus slave
    always_comb
    begin
        rif.hit   = 1'b1;
        rif.rdata = '0;
        unique case (rif.idx)
            CTRL_IDX:   rif.rdata = ctrl_view;
            PTR_LO_IDX: rif.rdata = active_pointer[BYTE_W-1:0];
            PTR_HI_IDX: rif.rdata = active_pointer[PTR_W-1:BYTE_W];
            default:    rif.hit   = 1'b0;
        endcase
    end

    // Registered view for the core; lags the pointer by one cycle
    always_ff @(posedge MCLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            active_pointer_q <= PTR_RESET;
        else
            active_pointer_q <= active_pointer;
    end

    assign ACTIVE_POINTER_OUT = active_pointer_q;
    assign POINTER_SELECT_OUT = pointer_select_q;

    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RSTN_IN);

    chk_swap_flips: assert property (
        ptr_move && auto_swap_enable_q && !wr_ctrl
        |=> pointer_select_q != $past(pointer_select_q))
        else $error("select did not flip after move");

    chk_swap_off: assert property (
        !auto_swap_enable_q && !wr_ctrl
        |=> $stable(pointer_select_q))
        else $error("select changed with auto-swap off");

    chk_spare_zero: assert property (
        wr_ctrl ##1 rif.idx == CTRL_IDX
        |-> rif.rdata[SPARE_HI_BIT] == 1'b0
            && rif.rdata[SPARE_LO_BIT] == 1'b0)
        else $error("spare control bit reads nonzero");

    chk_main_view: assert property (
        !pointer_select_q
        |=> ACTIVE_POINTER_OUT == $past(main_if.value))
        else $error("main pointer not presented");

    chk_shadow_view: assert property (
        pointer_select_q
        |=> ACTIVE_POINTER_OUT == $past(shadow_if.value))
        else $error("shadow pointer not presented");

    chk_idle_shadow: assert property (
        !pointer_select_q ##0 !shadow_if.ld_lo ##0 !shadow_if.ld_hi
        |=> $stable(shadow_if.value))
        else $error("unselected shadow pointer moved");

    chk_idle_main: assert property (
        pointer_select_q && !main_if.ld_lo && !main_if.ld_hi
        |=> $stable(main_if.value))
        else $error("unselected main pointer moved");

    chk_other_moves: assert property (
        MOVE_DONE_IN && !rif.wr
        && (MOVE_KIND_IN == MV_CODE_PC || MOVE_KIND_IN == MV_EXT_IDX)
        |=> $stable(main_if.value) && $stable(shadow_if.value)
            && $stable(pointer_select_q))
        else $error("non-pointer move adjusted state");

    chk_main_field: assert property (
        wr_ctrl
        |=> main_mode_q == $past(rif.wdata[MAIN_MODE_LSB +: MODE_W]))
        else $error("main mode field not taken");

    chk_shadow_field: assert property (
        wr_ctrl
        |=> shadow_mode_q == $past(rif.wdata[SHADOW_MODE_LSB +: MODE_W])
            && ctrl_view[SHADOW_MODE_LSB +: MODE_W] == shadow_mode_q)
        else $error("shadow mode field not taken");

    // Per-pointer adjust seen from the select side; byte loads excluded
    chk_main_inc: assert property (
        ptr_move && !pointer_select_q && !wr_lo && !wr_hi
        && main_mode_q == MODE_INC
        |=> main_if.value == $past(main_if.value) + PTR_ONE)
        else $error("main pointer did not increment");

    chk_shadow_inc: assert property (
        ptr_move && pointer_select_q && !wr_lo && !wr_hi
        && shadow_mode_q == MODE_INC
        |=> shadow_if.value == $past(shadow_if.value) + PTR_ONE)
        else $error("shadow pointer did not increment");

    chk_main_dec: assert property (
        ptr_move && !pointer_select_q && !wr_lo && !wr_hi
        && main_mode_q == MODE_DEC
        |=> main_if.value == $past(main_if.value) - PTR_ONE)
        else $error("main pointer did not decrement");

    chk_shadow_dec: assert property (
        ptr_move && pointer_select_q && !wr_lo && !wr_hi
        && shadow_mode_q == MODE_DEC
        |=> shadow_if.value == $past(shadow_if.value) - PTR_ONE)
        else $error("shadow pointer did not decrement");

    chk_shadow_tog: assert property (
        ptr_move && pointer_select_q && !wr_lo && !wr_hi
        && shadow_mode_q == MODE_TOG
        |=> shadow_if.value == ($past(shadow_if.value) ^ PTR_ONE))
        else $error("shadow pointer lsb not toggled");

    chk_main_tog: assert property (
        ptr_move && !pointer_select_q && !wr_lo && !wr_hi
        && main_mode_q == MODE_TOG
        |=> main_if.value == ($past(main_if.value) ^ PTR_ONE))
        else $error("main pointer lsb not toggled");

    chk_main_hold: assert property (
        ptr_move && !pointer_select_q && !wr_lo && !wr_hi
        && main_mode_q == MODE_HOLD
        |=> $stable(main_if.value))
        else $error("main pointer moved in hold mode");

    chk_shadow_hold: assert property (
        ptr_move && pointer_select_q && !wr_lo && !wr_hi
        && shadow_mode_q == MODE_HOLD
        |=> $stable(shadow_if.value))
        else $error("shadow pointer moved in hold mode");

    chk_sel_write: assert property (
        wr_ctrl |=> pointer_select_q == $past(rif.wdata[SEL_BIT]))
        else $error("select bit not taken");

    chk_swap_field: assert property (
        wr_ctrl |=> auto_swap_enable_q == $past(rif.wdata[SWAP_BIT]))
        else $error("auto-swap bit not taken");

    chk_main_lo_load: assert property (
        wr_lo && !pointer_select_q
        |=> main_if.value[BYTE_W-1:0] == $past(rif.wdata))
        else $error("main low byte not loaded");

    chk_main_hi_load: assert property (
        wr_hi && !pointer_select_q
        |=> main_if.value[PTR_W-1:BYTE_W] == $past(rif.wdata))
        else $error("main high byte not loaded");

    chk_shadow_lo_load: assert property (
        wr_lo && pointer_select_q
        |=> shadow_if.value[BYTE_W-1:0] == $past(rif.wdata))
        else $error("shadow low byte not loaded");

    chk_shadow_hi_load: assert property (
        wr_hi && pointer_select_q
        |=> shadow_if.value[PTR_W-1:BYTE_W] == $past(rif.wdata))
        else $error("shadow high byte not loaded");
endmodule // ddpc_top
`default_nettype wire

// >>> design/ddpc_pkg.sv
// Constants and types shared by the dual data pointer control block
package ddpc_pkg;
    localparam int unsigned ADDR_W          = 12;
    localparam int unsigned DATA_W          = 32;
    localparam int unsigned BYTE_W          = 8;
    localparam int unsigned PTR_W           = 16;
    localparam int unsigned MODE_W          = 2;
    localparam int unsigned IDX_LSB         = 2;
    localparam int unsigned IDX_W           = 8;
    // Register indices; byte address is four times the index
    localparam logic [7:0]  CTRL_IDX        = 8'hA7;
    localparam logic [7:0]  PTR_LO_IDX      = 8'hA4;
    localparam logic [7:0]  PTR_HI_IDX      = 8'hA5;
    // Control field positions
    localparam int unsigned SEL_BIT         = 0;
    localparam int unsigned SPARE_LO_BIT    = 1;
    localparam int unsigned MAIN_MODE_LSB   = 2;
    localparam int unsigned SHADOW_MODE_LSB = 4;
    localparam int unsigned SWAP_BIT        = 6;
    localparam int unsigned SPARE_HI_BIT    = 7;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [15:0] PTR_RESET       = 16'h0000;
    localparam logic [15:0] PTR_ONE         = 16'h0001;
    localparam logic [31:0] RDATA_ZERO      = 32'h0000_0000;

    typedef enum logic [1:0] {
        MODE_HOLD = 2'b00,
        MODE_INC  = 2'b01,
        MODE_DEC  = 2'b10,
        MODE_TOG  = 2'b11
    } ddpc_mode_type;

    typedef enum logic [1:0] {
        MV_EXT_PTR  = 2'b00,
        MV_CODE_PTR = 2'b01,
        MV_CODE_PC  = 2'b10,
        MV_EXT_IDX  = 2'b11
    } ddpc_move_type;
endpackage

// >>> design/ddpc_if.sv
// Carriers between the top, the bus slave and the pointer units
`timescale 1ns/1ps
`default_nettype none
interface ddpc_ptr_if;
    import ddpc_pkg::*;
    logic                ld_lo;
    logic                ld_hi;
    logic [BYTE_W-1:0]   wbyte;
    logic                step;
    ddpc_mode_type       mode;
    logic [PTR_W-1:0]    value;
    modport unit (input ld_lo, ld_hi, wbyte, step, mode, output value);
    modport ctrl (output ld_lo, ld_hi, wbyte, step, mode, input value);
endinterface // ddpc_ptr_if

interface ddpc_reg_if;
    import ddpc_pkg::*;
    logic                wr;
    logic [IDX_W-1:0]    idx;
    logic [BYTE_W-1:0]   wdata;
    logic                hit;
    logic [BYTE_W-1:0]   rdata;
    modport bus  (output wr, idx, wdata, input hit, rdata);
    modport regs (input wr, idx, wdata, output hit, rdata);
endinterface // ddpc_reg_if
`default_nettype wire

// >>> design/ddpc_ptr_unit.sv
// One 16-bit data pointer with byte loads and post-move adjust
`timescale 1ns/1ps
`default_nettype none
module ddpc_ptr_unit (
    input  wire logic   clk_in,
    input  wire logic   rstn_in,
    ddpc_ptr_if.unit    p
);
    import ddpc_pkg::*;

    logic [PTR_W-1:0] value_q;

    // Byte load beats a same-cycle adjust
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            value_q <= PTR_RESET;
        else if (p.ld_lo)
            value_q[BYTE_W-1:0] <= p.wbyte;
        else if (p.ld_hi)
            value_q[PTR_W-1:BYTE_W] <= p.wbyte;
        else if (p.step)
        begin
            unique case (p.mode)
                MODE_HOLD: value_q <= value_q;
                MODE_INC:  value_q <= value_q + PTR_ONE;
                MODE_DEC:  value_q <= value_q - PTR_ONE;
                MODE_TOG:  value_q <= value_q ^ PTR_ONE;
            endcase
        end
    end

    assign p.value = value_q;

    chk_inc_step: assert property (@(posedge clk_in) disable iff (!rstn_in)
        p.step && !p.ld_lo && !p.ld_hi && p.mode == MODE_INC
        |=> p.value == $past(p.value) + PTR_ONE)
        else $error("pointer did not increment");
    chk_dec_step: assert property (@(posedge clk_in) disable iff (!rstn_in)
        p.step && !p.ld_lo && !p.ld_hi && p.mode == MODE_DEC
        |=> p.value == $past(p.value) - PTR_ONE)
        else $error("pointer did not decrement");
    chk_tog_step: assert property (@(posedge clk_in) disable iff (!rstn_in)
        p.step && !p.ld_lo && !p.ld_hi && p.mode == MODE_TOG
        |=> (p.value ^ $past(p.value)) == PTR_ONE)
        else $error("pointer lsb not toggled alone");
    chk_hold_step: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !p.ld_lo && !p.ld_hi && (!p.step || p.mode == MODE_HOLD)
        |=> $stable(p.value))
        else $error("pointer changed without cause");
endmodule // ddpc_ptr_unit
`default_nettype wire

// >>> design/ddpc_apb_slave.sv
// Zero-wait APB slave front end for the pointer control registers
`timescale 1ns/1ps
`default_nettype none
module ddpc_apb_slave (
    input  wire logic                        clk_in,
    input  wire logic                        rstn_in,
    input  wire logic                        psel_in,
    input  wire logic                        penable_in,
    input  wire logic                        pwrite_in,
    input  wire logic [ddpc_pkg::ADDR_W-1:0] paddr_in,
    input  wire logic [ddpc_pkg::DATA_W-1:0] pwdata_in,
    output logic      [ddpc_pkg::DATA_W-1:0] prdata_out,
    output logic                             pready_out,
    output logic                             pslverr_out,
    ddpc_reg_if.bus                          r
);
    import ddpc_pkg::*;

    logic              setup;
    logic              ok;
    logic              pready_q;
    logic              pslverr_q;
    logic [DATA_W-1:0] prdata_q;

    assign setup   = psel_in && !penable_in;
    assign r.idx   = paddr_in[IDX_LSB +: IDX_W];
    assign r.wdata = pwdata_in[BYTE_W-1:0];
    // Misaligned or out-of-range addresses are errors, not aliases
    assign ok = r.hit && (paddr_in[IDX_LSB-1:0] == '0)
                && (paddr_in[ADDR_W-1:IDX_LSB+IDX_W] == '0);
    assign r.wr = psel_in && penable_in && pready_q && pwrite_in
                  && !pslverr_q;

    // Answer decided in setup, shown for exactly the access cycle
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= RDATA_ZERO;
        end
        else
        begin
            pready_q  <= setup;
            pslverr_q <= setup && !ok;
            prdata_q  <= (setup && ok && !pwrite_in) ?
                         {{(DATA_W-BYTE_W){1'b0}}, r.rdata} : RDATA_ZERO;
        end
    end

    assign prdata_out  = prdata_q;
    assign pready_out  = pready_q;
    assign pslverr_out = pslverr_q;
endmodule // ddpc_apb_slave
`default_nettype wire

// >>> verification/ddpc_top_tb_top.sv
// Self-checking bench for the dual data pointer control block
`timescale 1ns/1ps
`default_nettype none
`define DDPC_CHK(what, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("ERROR %s expected %h seen %h", what, exp, got); \
        end \
    end
module ddpc_top_tb_top;
    import ddpc_pkg::*;
    typedef struct {
        string             what;
        logic              is_rd;
        logic [DATA_W-1:0] rdata;
        logic              err;
    } ddpc_note_type;
    localparam logic [ADDR_W-1:0] CTRL_A = 12'h29C;
    localparam logic [ADDR_W-1:0] LO_A   = 12'h290;
    localparam logic [ADDR_W-1:0] HI_A   = 12'h294;
    // Wrap edges sit in the table so inc and dec cross them
    localparam logic [PTR_W-1:0] STARTS [4] =
        '{16'h1234, 16'hFFFF, 16'h0000, 16'hAAAA};
    logic                mclk;
    logic                rstn;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [ADDR_W-1:0]   paddr;
    logic [DATA_W-1:0]   pwdata;
    logic [DATA_W-1:0]   prdata;
    logic                pready;
    logic                pslverr;
    logic                move_done;
    ddpc_move_type       move_kind;
    logic [PTR_W-1:0]    act_ptr;
    logic                sel_out;
    int                  failures;
    int                  tests_run;
    int                  cycles;
    ddpc_note_type       notes [$];
    logic [PTR_W-1:0]    m_ptr [2];
    logic [BYTE_W-1:0]   m_ctrl;

    ddpc_top ddpc_top_i (
        .MCLK_IN            (mclk),
        .RSTN_IN            (rstn),
        .PSEL_IN            (psel),
        .PENABLE_IN         (penable),
        .PWRITE_IN          (pwrite),
        .PADDR_IN           (paddr),
        .PWDATA_IN          (pwdata),
        .PRDATA_OUT         (prdata),
        .PREADY_OUT         (pready),
        .PSLVERR_OUT        (pslverr),
        .MOVE_DONE_IN       (move_done),
        .MOVE_KIND_IN       (move_kind),
        .ACTIVE_POINTER_OUT (act_ptr),
        .POINTER_SELECT_OUT (sel_out)
    );

    always #10 mclk = ~mclk;

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Timeout ceiling well above the few thousand cycles needed
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            failures++;
            end_of_test();
        end
    end

    // Result watcher: oldest note meets each completed transfer
    always @(posedge mclk)
    begin
        ddpc_note_type n;
        if (psel && penable && pready === 1'b1)
        begin
            n = notes.pop_front();
            `DDPC_CHK({n.what, " err"}, n.err, pslverr)
            if (n.is_rd)
                `DDPC_CHK(n.what, n.rdata, prdata)
        end
    end

    function automatic logic [BYTE_W-1:0] exp_byte(logic [ADDR_W-1:0] a);
        case (a)
            CTRL_A:  return m_ctrl;
            LO_A:    return m_ptr[m_ctrl[SEL_BIT]][7:0];
            HI_A:    return m_ptr[m_ctrl[SEL_BIT]][15:8];
            default: return 8'h00;
        endcase
    endfunction

    task automatic model_write(logic [ADDR_W-1:0] a, logic [BYTE_W-1:0] d);
        case (a)
            CTRL_A: m_ctrl = d & 8'h7D;
            LO_A:   m_ptr[m_ctrl[SEL_BIT]][7:0] = d;
            HI_A:   m_ptr[m_ctrl[SEL_BIT]][15:8] = d;
            default: ;
        endcase
    endtask

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [BYTE_W-1:0] wd, input logic err,
                       input string what);
        ddpc_note_type n;
        int            k;
        n.what = what;
        n.is_rd = !wr;
        n.err = err;
        n.rdata = err ? RDATA_ZERO : {24'h00_0000, exp_byte(a)};
        @(posedge mclk);
        notes.push_back(n);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'($urandom()), wd};
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
            failures++;
        if (wr && !err)
            model_write(a, wd);
    endtask

    task automatic moves(input int n, input logic rnd,
                         input ddpc_move_type k0);
        ddpc_move_type k;
        logic          s;
        logic [1:0]    md;
        for (int i = 0; i < n; i++)
        begin
            @(posedge mclk);
            k = rnd ? ddpc_move_type'($urandom_range(3)) : k0;
            move_done <= 1'b1;
            move_kind <= k;
            if (k == MV_EXT_PTR || k == MV_CODE_PTR)
            begin
                s = m_ctrl[SEL_BIT];
                md = s ? m_ctrl[5:4] : m_ctrl[3:2];
                case (md)
                    MODE_INC: m_ptr[s] = m_ptr[s] + 16'h0001;
                    MODE_DEC: m_ptr[s] = m_ptr[s] - 16'h0001;
                    MODE_TOG: m_ptr[s] = m_ptr[s] ^ 16'h0001;
                    default: ;
                endcase
                if (m_ctrl[SWAP_BIT])
                    m_ctrl[SEL_BIT] = !s;
            end
        end
        @(posedge mclk);
        move_done <= 1'b0;
    endtask

    task automatic check_all(input string what);
        apb(1'b0, CTRL_A, 8'h00, 1'b0, {what, " ctrl"});
        apb(1'b0, LO_A, 8'h00, 1'b0, {what, " lo"});
        apb(1'b0, HI_A, 8'h00, 1'b0, {what, " hi"});
        `DDPC_CHK({what, " act"}, m_ptr[m_ctrl[SEL_BIT]], act_ptr)
        `DDPC_CHK({what, " sel"}, m_ctrl[SEL_BIT], sel_out)
    endtask

    task automatic set_ptrs(input logic [PTR_W-1:0] a, b,
                            input logic [BYTE_W-1:0] c);
        apb(1'b1, CTRL_A, 8'h00, 1'b0, "sel main");
        apb(1'b1, LO_A, a[7:0], 1'b0, "main lo");
        apb(1'b1, HI_A, a[15:8], 1'b0, "main hi");
        apb(1'b1, CTRL_A, 8'h01, 1'b0, "sel shadow");
        apb(1'b1, LO_A, b[7:0], 1'b0, "shadow lo");
        apb(1'b1, HI_A, b[15:8], 1'b0, "shadow hi");
        apb(1'b1, CTRL_A, c, 1'b0, "ctrl");
    endtask

    initial
    begin
        logic [BYTE_W-1:0] swaps [3];
        mclk = 1'b0;
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        move_done = 1'b0;
        move_kind = MV_EXT_PTR;
        failures = 0;
        tests_run = 0;
        cycles = 0;
        m_ptr[0] = PTR_RESET;
        m_ptr[1] = PTR_RESET;
        m_ctrl = CTRL_RESET;
        swaps = '{8'h55, 8'h79, 8'h4E};
        void'($urandom(32'h3576));
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        check_all("reset");
        apb(1'b1, CTRL_A, 8'hFF, 1'b0, "ctrl ones");
        check_all("spare bits");
        apb(1'b1, 12'h2A0, 8'h00, 1'b1, "unmapped wr");
        apb(1'b0, 12'h29D, 8'h00, 1'b1, "misaligned rd");
        apb(1'b1, 12'hE9C, 8'h00, 1'b1, "high bits wr");
        check_all("refused");
        for (int mm = 0; mm < 4; mm++)
            for (int sm = 0; sm < 4; sm++)
            begin
                set_ptrs(STARTS[mm], STARTS[sm],
                         {2'b00, 2'(sm), 2'(mm), 2'b00});
                for (int s = 0; s < 2; s++)
                begin
                    apb(1'b1, CTRL_A, {m_ctrl[7:1], 1'(s)}, 1'b0, "sel");
                    for (int k = 0; k < 4; k++)
                    begin
                        moves(2, 1'b0, ddpc_move_type'(k));
                        check_all("modes");
                    end
                end
            end
        // Back-to-back moves with auto-swap, then random kinds
        foreach (swaps[i])
        begin
            set_ptrs(16'($urandom()), 16'($urandom()), swaps[i]);
            moves(9, 1'b0, MV_CODE_PTR);
            check_all("swap burst");
            moves(8, 1'b1, MV_EXT_PTR);
            check_all("swap random");
        end
        // Second reset in mid-run
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        m_ptr[0] = PTR_RESET;
        m_ptr[1] = PTR_RESET;
        m_ctrl = CTRL_RESET;
        check_all("second reset");
        end_of_test();
    end
endmodule // ddpc_top_tb_top
`undef DDPC_CHK
`default_nettype wire
